/* hdl/balance_route.sv */
// Purpose: Steers each balancing-enable bit to balancing or bleed drive
// Assumes: Enable bits stable per cycle
// Notes: Exactly one destination per channel enabled in the previous cycle, none for a disabled one
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"
module balance_route (
	input wire logic i_clk,
	input wire logic i_rst_n,
	stc_if.route bus
);
	stc_pkg::chan_vec_t bal_q;
	stc_pkg::chan_vec_t bleed_q;

	genvar ch;
	generate
		for (ch = 0; ch < `STC_CHANNELS; ch = ch + 1) begin : g_chan
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					bal_q[ch] <= 1'b0;
					bleed_q[ch] <= 1'b0;
				end else begin
					bal_q[ch] <= bus.bal_en[ch] & ~bus.bleed_sel;
					bleed_q[ch] <= bus.bal_en[ch] & bus.bleed_sel;
				end
			end
		end
	endgenerate

	assign bus.bal_drive = bal_q;
	assign bus.bleed_drive = bleed_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_route_bleed: assert property (bus.bleed_sel |=> (bleed_q == $past(bus.bal_en)) && (bal_q == 16'h0000))
		else $error("Bleed mode routing wrong");
	a_route_balance: assert property (!bus.bleed_sel |=> (bal_q == $past(bus.bal_en)) && (bleed_q == 16'h0000))
		else $error("Balance mode routing wrong");
	c_bleed_drive: cover property (bus.bleed_sel && (bus.bal_en != 16'h0000) ##1 (bleed_q != 16'h0000));
endmodule : balance_route
`default_nettype wire

/* hdl/self_test_config_top.sv */
// Purpose: Self-test configuration register bank of a battery monitor
// Assumes: Single 200 MHz clock; register port strobes one cycle, read data one cycle later
// Notes: Drives regulator test, counter reset gating, trip arming, bleed routing, monitor enables
//
// Notes on behaviour
// - Bits 15..12 read zero, host writes zero
// - Inhibit bit blocks packet reset of timeout counter
// - Lowered period while inhibited may miss timeout
// - Armed supply trip forces shutdown
// - Arming survives clear; only shutdown disarms
// - Bleed select connects resistors, remaps balancing bits
// - Bleed mode: enable bits drive bleed resistors
// - Bit 2 enables negative pump monitor
// - Bit 0 enables stack voltage monitor
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"
module self_test_config_top (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [`STC_ADDR_W-1:0] i_addr,
	input wire logic [`STC_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`STC_DATA_W-1:0] o_rdata,
	input wire logic i_valid_packet,
	input wire logic i_supply_trip,
	input wire logic i_in_shutdown,
	input wire logic [`STC_CHANNELS-1:0] i_balance_enable,
	output logic o_comm_counter_reset,
	output logic o_comm_counter_reset_inhibit,
	output logic [3:0] o_regulator_test_ctl,
	output logic o_shutdown_req,
	output logic o_wire_bleed_select,
	output logic [`STC_CHANNELS-1:0] o_balance_drive,
	output logic [`STC_CHANNELS-1:0] o_bleed_drive,
	output logic o_negative_pump_monitor_en,
	output logic o_stack_voltage_monitor_en
);
	logic [`STC_DATA_W-1:0] cfg_q;
	logic [`STC_DATA_W-1:0] rdata_q;
	logic counter_reset_q;
	logic wr_cfg;
	logic rd_cfg;
	logic rd_status;
	logic [`STC_DATA_W-1:0] status_word;
	logic [`STC_DATA_W-1:0] rdata_d;

	stc_if link ();

	assign wr_cfg = i_wr && (i_addr == `STC_OFF_SELF_TEST_CFG);
	assign rd_cfg = i_rd && (i_addr == `STC_OFF_SELF_TEST_CFG);
	assign rd_status = i_rd && (i_addr == `STC_OFF_STATUS);

	// Configuration store; reserved bits never latch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_q <= `STC_CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= i_wdata & `STC_CFG_WRITE_MASK;
		end
	end

	always_comb begin
		status_word = `STC_STATUS_RESET;
		status_word[`STC_POS_STATUS_ARMED] = link.armed;
		status_word[`STC_POS_STATUS_TRIPPED] = link.tripped;
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (rd_cfg) begin
			rdata_d = cfg_q & `STC_CFG_WRITE_MASK;
		end else if (rd_status) begin
			rdata_d = status_word;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Valid packet restarts the timeout unless inhibited; a period change then may miss it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			counter_reset_q <= 1'b0;
		end else begin
			counter_reset_q <= i_valid_packet & ~cfg_q[`STC_POS_CNT_RST_INHIBIT];
		end
	end

	assign link.arm_set = wr_cfg & i_wdata[`STC_POS_TRIP_SHUTDOWN];
	assign link.shutdown_level = i_in_shutdown;
	assign link.supply_trip = i_supply_trip;
	assign link.bleed_sel = cfg_q[`STC_POS_BLEED_SEL];
	assign link.bal_en = i_balance_enable;

	trip_arm u_trip_arm (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(link)
	);

	balance_route u_balance_route (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(link)
	);

	assign o_rdata = rdata_q;
	assign o_comm_counter_reset = counter_reset_q;
	assign o_comm_counter_reset_inhibit = cfg_q[`STC_POS_CNT_RST_INHIBIT];
	assign o_regulator_test_ctl = cfg_q[`STC_POS_REG_TEST_MSB:`STC_POS_REG_TEST_LSB];
	assign o_shutdown_req = link.shutdown_req;
	assign o_wire_bleed_select = cfg_q[`STC_POS_BLEED_SEL];
	assign o_balance_drive = link.bal_drive;
	assign o_bleed_drive = link.bleed_drive;
	assign o_negative_pump_monitor_en = cfg_q[`STC_POS_PUMP_MON_EN];
	assign o_stack_voltage_monitor_en = cfg_q[`STC_POS_STACK_MON_EN];

	// Helper: marks the first cycle after reset release
	logic first_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_reserved_read_zero: assert property (i_rd |=> o_rdata[15:12] == 4'h0 && o_rdata[5] == 1'b0)
		else $error("Reserved bits read nonzero");
	a_cfg_readback: assert property (rd_cfg |=> o_rdata == (cfg_q & 16'h0fd5))
		else $error("Configuration readback mismatch");
	a_write_then_read: assert property (wr_cfg ##1 rd_cfg |=> o_rdata == ($past(i_wdata, 2) & 16'h0fd5))
		else $error("Written value not returned");
	a_counter_blocked: assert property (i_valid_packet && cfg_q[7] |=> !o_comm_counter_reset)
		else $error("Packet reset counter while inhibited");
	a_counter_passes: assert property (i_valid_packet && !cfg_q[7] |=> o_comm_counter_reset)
		else $error("Packet failed to reset counter");
	a_bleed_follows: assert property (wr_cfg |=> o_wire_bleed_select == $past(i_wdata[4]))
		else $error("Bleed select not following write");
	a_pump_monitor: assert property (wr_cfg |=> o_negative_pump_monitor_en == $past(i_wdata[2]))
		else $error("Pump monitor enable wrong");
	a_stack_monitor: assert property (wr_cfg |=> o_stack_voltage_monitor_en == $past(i_wdata[0]))
		else $error("Stack monitor enable wrong");
	a_reset_zero: assert property (first_q |-> cfg_q == 16'h0000 && !o_shutdown_req)
		else $error("Register not zero after reset");
	a_arm_survives_clear: assert property (wr_cfg && i_wdata[6] ##1 (wr_cfg && !i_wdata[6] && !i_in_shutdown)
		|=> link.armed)
		else $error("Clearing the bit disarmed the trip");

	// Field outputs take the written value and hold it between writes
	a_regtest_follows: assert property (wr_cfg |=> o_regulator_test_ctl == $past(i_wdata[11:8]))
		else $error("Regulator test field not following write");
	a_inhibit_follows: assert property (wr_cfg |=> o_comm_counter_reset_inhibit == $past(i_wdata[7]))
		else $error("Inhibit bit not following write");
	a_regtest_holds: assert property (!wr_cfg |=> $stable(o_regulator_test_ctl))
		else $error("Regulator test field changed without write");
	a_inhibit_holds: assert property (!wr_cfg |=> $stable(o_comm_counter_reset_inhibit))
		else $error("Inhibit bit changed without write");
	a_bleed_holds: assert property (!wr_cfg |=> $stable(o_wire_bleed_select))
		else $error("Bleed select changed without write");
	a_pump_holds: assert property (!wr_cfg |=> $stable(o_negative_pump_monitor_en))
		else $error("Pump monitor enable changed without write");
	a_stack_holds: assert property (!wr_cfg |=> $stable(o_stack_voltage_monitor_en))
		else $error("Stack monitor enable changed without write");

	// Register port behaviour
	a_reserved_not_stored: assert property (wr_cfg |=> cfg_q[15:12] == 4'h0 && !cfg_q[5] && !cfg_q[3] && !cfg_q[1])
		else $error("Reserved bit stored");
	a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("Read data not zero outside read");
	a_status_read: assert property (rd_status |=> o_rdata == {14'h0000, $past(link.tripped), $past(link.armed)})
		else $error("Status readback wrong");

	// Trip arming and shutdown request
	a_arm_on_write: assert property (wr_cfg && i_wdata[6] |=> link.armed)
		else $error("Trip not armed by write");
	a_shutdown_holds: assert property (o_shutdown_req && !i_in_shutdown |=> o_shutdown_req)
		else $error("Shutdown request dropped before shutdown");
	a_entry_disarms: assert property ($rose(i_in_shutdown) && !wr_cfg && !i_supply_trip |=> !link.armed)
		else $error("Shutdown entry did not disarm");

	// Routing and counter reset
	a_routes_exclusive: assert property ((o_balance_drive & o_bleed_drive) == 16'h0000)
		else $error("Channel driven to both destinations");
	a_packet_only: assert property (!i_valid_packet |=> !o_comm_counter_reset)
		else $error("Counter reset without packet");

	c_inhibit_packet: cover property (cfg_q[7] && i_valid_packet);
	c_clear_then_trip: cover property (wr_cfg && !i_wdata[6] && link.armed ##[1:10] o_shutdown_req);
	c_both_monitors: cover property (o_negative_pump_monitor_en && o_stack_voltage_monitor_en);
endmodule : self_test_config_top
`default_nettype wire

/* hdl/stc_if.sv */
// Purpose: Carrier between the bank and its trip and routing helpers
// Assumes: Single clock domain
// Notes: Top drives requests, helpers return registered results
`timescale 1ns/1ps
`default_nettype none
interface stc_if;
	logic arm_set;
	logic shutdown_level;
	logic supply_trip;
	logic armed;
	logic tripped;
	logic shutdown_req;
	logic bleed_sel;
	stc_pkg::chan_vec_t bal_en;
	stc_pkg::chan_vec_t bal_drive;
	stc_pkg::chan_vec_t bleed_drive;

	modport ctrl (
		output arm_set, shutdown_level, supply_trip, bleed_sel, bal_en,
		input armed, tripped, shutdown_req, bal_drive, bleed_drive
	);
	modport trip (
		input arm_set, shutdown_level, supply_trip,
		output armed, tripped, shutdown_req
	);
	modport route (
		input bleed_sel, bal_en,
		output bal_drive, bleed_drive
	);
endinterface : stc_if
`default_nettype wire

/* hdl/stc_params.svh */
// Purpose: Offsets, field positions, reset values and masks of the self-test configuration bank
// Assumes: 8-bit register address, 16-bit register data
// Notes: Definitions only
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

`define STC_ADDR_W 8
`define STC_DATA_W 16
`define STC_CHANNELS 16

`define STC_OFF_SELF_TEST_CFG 8'h1e
`define STC_OFF_STATUS 8'h40

`define STC_POS_REG_TEST_LSB 8
`define STC_POS_REG_TEST_MSB 11
`define STC_POS_CNT_RST_INHIBIT 7
`define STC_POS_TRIP_SHUTDOWN 6
`define STC_POS_BLEED_SEL 4
`define STC_POS_PUMP_MON_EN 2
`define STC_POS_STACK_MON_EN 0
`define STC_POS_STATUS_ARMED 0
`define STC_POS_STATUS_TRIPPED 1

`define STC_CFG_WRITE_MASK 16'h0fd5
`define STC_CFG_RESET 16'h0000
`define STC_STATUS_RESET 16'h0000

`define STC_MISSED_TIMEOUT_MIN 70

`endif

/* hdl/stc_pkg.sv */
// Purpose: Types shared by the self-test configuration bank
// Assumes: Constants live in stc_params.svh
// Notes: Gray-coded arm states
package stc_pkg;

	typedef enum logic [1:0] {
		ARM_IDLE = 2'b00,
		ARM_ARMED = 2'b01,
		ARM_TRIPPED = 2'b11
	} arm_state_t;

	typedef logic [15:0] chan_vec_t;

endpackage : stc_pkg

/* hdl/trip_arm.sv */
// Purpose: Sticky arming of shutdown on a digital supply trip
// Assumes: Trip and shutdown levels synchronous to i_clk
// Notes: Arming survives a software clear; only shutdown entry disarms
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"
module trip_arm (
	input wire logic i_clk,
	input wire logic i_rst_n,
	stc_if.trip bus
);
	stc_pkg::arm_state_t state_q, state_d;
	logic shutdown_prev_q;
	logic shutdown_entry;
	logic shutdown_req_q;

	assign shutdown_entry = bus.shutdown_level & ~shutdown_prev_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			stc_pkg::ARM_IDLE: begin
				if (bus.arm_set) begin
					state_d = stc_pkg::ARM_ARMED;
				end
			end
			stc_pkg::ARM_ARMED: begin
				if (bus.supply_trip) begin
					state_d = stc_pkg::ARM_TRIPPED;
				end else if (shutdown_entry && !bus.arm_set) begin
					state_d = stc_pkg::ARM_IDLE;
				end
			end
			stc_pkg::ARM_TRIPPED: begin
				if (shutdown_entry) begin
					state_d = bus.arm_set ? stc_pkg::ARM_ARMED : stc_pkg::ARM_IDLE;
				end
			end
			default: begin
				state_d = stc_pkg::ARM_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= stc_pkg::ARM_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shutdown_prev_q <= 1'b0;
		end else begin
			shutdown_prev_q <= bus.shutdown_level;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shutdown_req_q <= 1'b0;
		end else begin
			shutdown_req_q <= (state_d == stc_pkg::ARM_TRIPPED);
		end
	end

	assign bus.armed = (state_q != stc_pkg::ARM_IDLE);
	assign bus.tripped = (state_q == stc_pkg::ARM_TRIPPED);
	assign bus.shutdown_req = shutdown_req_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_trip_to_shutdown: assert property ((state_q == stc_pkg::ARM_ARMED) && bus.supply_trip |=> shutdown_req_q)
		else $error("Armed trip did not request shutdown");
	a_arm_sticky: assert property (bus.armed && !shutdown_entry |=> bus.armed)
		else $error("Arming lost without shutdown entry");
	a_idle_no_trip: assert property (!bus.armed && !bus.arm_set |=> !shutdown_req_q)
		else $error("Shutdown requested while disarmed");
	c_arm_then_trip: cover property (bus.arm_set ##[1:20] shutdown_req_q);
endmodule : trip_arm
`default_nettype wire

/* tb/tb_self_test_config_top.sv */
// Purpose: Self-checking bench for the self-test configuration bank
// Assumes: Read data one cycle after the read strobe
// Notes: Model tracks the config word; bit 6 kept out of the random loop
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"
module tb_self_test_config_top;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_valid_packet = 1'b0;
	logic i_supply_trip = 1'b0;
	logic i_in_shutdown = 1'b0;
	logic [15:0] i_balance_enable = 16'h0000;
	logic [15:0] o_rdata;
	logic o_comm_counter_reset;
	logic o_comm_counter_reset_inhibit;
	logic [3:0] o_regulator_test_ctl;
	logic o_shutdown_req;
	logic o_wire_bleed_select;
	logic [15:0] o_balance_drive;
	logic [15:0] o_bleed_drive;
	logic o_negative_pump_monitor_en;
	logic o_stack_voltage_monitor_en;
	integer fail_count = 0;
	integer cmp_count = 0;
	integer seed = 32'h530cefce;
	logic [15:0] cfg = 16'h0000;
	logic [15:0] v;
	logic [15:0] got;
	integer i;
	always #2.5 i_clk = ~i_clk;
	self_test_config_top self_test_config_top_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_valid_packet(i_valid_packet), .i_supply_trip(i_supply_trip),
		.i_in_shutdown(i_in_shutdown), .i_balance_enable(i_balance_enable),
		.o_comm_counter_reset(o_comm_counter_reset), .o_comm_counter_reset_inhibit(o_comm_counter_reset_inhibit),
		.o_regulator_test_ctl(o_regulator_test_ctl), .o_shutdown_req(o_shutdown_req),
		.o_wire_bleed_select(o_wire_bleed_select), .o_balance_drive(o_balance_drive), .o_bleed_drive(o_bleed_drive),
		.o_negative_pump_monitor_en(o_negative_pump_monitor_en),
		.o_stack_voltage_monitor_en(o_stack_voltage_monitor_en)
	);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		if (a == `STC_OFF_SELF_TEST_CFG) cfg = d & `STC_CFG_WRITE_MASK;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic chk_out;
		chk({12'h000, o_regulator_test_ctl}, {12'h000, cfg[11:8]});
		chk({15'h0000, o_comm_counter_reset_inhibit}, {15'h0000, cfg[7]});
		chk({15'h0000, o_wire_bleed_select}, {15'h0000, cfg[4]});
		chk({15'h0000, o_negative_pump_monitor_en}, {15'h0000, cfg[2]});
		chk({15'h0000, o_stack_voltage_monitor_en}, {15'h0000, cfg[0]});
	endtask : chk_out
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4000) @(posedge i_clk);
		fail_count++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		chk_out;
		chk(o_balance_drive | o_bleed_drive, 16'h0000);
		chk({14'h0000, o_shutdown_req, o_comm_counter_reset}, 16'h0000);
		rd(`STC_OFF_SELF_TEST_CFG, got);
		chk(got, 16'h0000);
		// Period, timeout count and keep-balancing bit live elsewhere; never touched
		for (i = 0; i < 24; i++) begin
			// Reserved bits written as zero, arming bit kept clear
			wr(`STC_OFF_SELF_TEST_CFG, 16'($random(seed)) & 16'h0f95);
			chk_out;
			wr(8'h1f, 16'($random(seed)));
			rd(`STC_OFF_SELF_TEST_CFG, got);
			chk(got, cfg);
			rd(8'h1f, got);
			chk(got, 16'h0000);
			@(posedge i_clk);
			#1;
			chk(o_rdata, 16'h0000);
			v = 16'($random(seed));
			@(posedge i_clk);
			i_balance_enable <= v;
			i_valid_packet <= 1'b1;
			@(posedge i_clk);
			i_valid_packet <= 1'b0;
			#1;
			chk(o_balance_drive, cfg[4] ? 16'h0000 : v);
			chk(o_bleed_drive, cfg[4] ? v : 16'h0000);
			chk({15'h0000, o_comm_counter_reset}, {15'h0000, ~cfg[7]});
		end
		wr(`STC_OFF_SELF_TEST_CFG, 16'h0040);
		wr(`STC_OFF_SELF_TEST_CFG, 16'h0000);
		rd(`STC_OFF_SELF_TEST_CFG, got);
		chk(got, 16'h0000);
		rd(`STC_OFF_STATUS, got);
		chk(got, 16'h0001);
		@(posedge i_clk);
		i_supply_trip <= 1'b1;
		@(posedge i_clk);
		i_supply_trip <= 1'b0;
		#1;
		chk({15'h0000, o_shutdown_req}, 16'h0001);
		repeat (3) @(posedge i_clk);
		#1;
		chk({15'h0000, o_shutdown_req}, 16'h0001);
		rd(`STC_OFF_STATUS, got);
		chk(got, 16'h0003);
		@(posedge i_clk);
		i_in_shutdown <= 1'b1;
		@(posedge i_clk);
		i_in_shutdown <= 1'b0;
		#1;
		chk({15'h0000, o_shutdown_req}, 16'h0000);
		rd(`STC_OFF_STATUS, got);
		chk(got, 16'h0000);
		@(posedge i_clk);
		i_supply_trip <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_supply_trip <= 1'b0;
		#1;
		chk({15'h0000, o_shutdown_req}, 16'h0000);
		end_of_test;
	end
endmodule : tb_self_test_config_top
`default_nettype wire
